// ==== fwsr_pkg.sv ====
// package of constants for the flash write-status polling controller
package fwsr_pkg;
  // data bus bit positions of the status byte
  localparam int unsigned BIT_POLL   = 7;
  localparam int unsigned BIT_TOG1   = 6;
  localparam int unsigned BIT_FAIL   = 5;
  localparam int unsigned BIT_TIMER  = 3;
  localparam int unsigned BIT_TOG2   = 2;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_ADDR    = 4'h4;
  localparam logic [3:0] OFF_STAT    = 4'h8;
  localparam logic [3:0] OFF_DATA    = 4'hC;
  // control register fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_USECE = 1;
  localparam int unsigned CTRL_TOGB  = 2;
  localparam int unsigned CTRL_ABORT = 3;
  // status register fields
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_FAIL    = 2;
  localparam int unsigned ST_RDYPIN  = 3;
  localparam int unsigned ST_TIMER   = 4;
  localparam int unsigned ST_RSTREQ  = 5;
  // reset values
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [17:0] RST_ADDR   = 18'h0_0000;
  // flash reset command
  localparam logic [7:0]  CMD_RESET  = 8'hF0;
  // read strobe timing, figures in ns at 8 ns clock
  localparam int unsigned CLK_NS     = 8;
  localparam int unsigned TRC_NS     = 120;
  localparam int unsigned TRC_CYC    = (TRC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TGAP_NS    = 40;
  localparam int unsigned TGAP_CYC   = (TGAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0]  TRC_CNT    = 5'(TRC_CYC);
  localparam logic [4:0]  TGAP_CNT   = 5'(TGAP_CYC);
endpackage

// ==== fwsr_cyc_if.sv ====
// interface between poll sequencer and flash bus cycle engine
`timescale 1ns/1ns
interface fwsr_cyc_if;
  logic       req;   // start one bus cycle
  logic       wr;    // 1 = write cycle
  logic       use_ce; // delimit read cycle by chip select
  logic [17:0] addr; // cycle address
  logic [7:0] wdata; // write data
  logic       done;  // one-cycle pulse, cycle ended
  logic [7:0] rdata; // data sampled at end of read
  modport seq (output req, wr, use_ce, addr, wdata, input done, rdata);
  modport eng (input req, wr, use_ce, addr, wdata, output done, rdata);
endinterface

// ==== fwsr_cycle.sv ====
// flash bus cycle engine: one read or write strobe cycle per request
`timescale 1ns/1ns
module fwsr_cycle (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  fwsr_cyc_if.eng          cyc,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  output logic      [17:0] addr_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o
);
  typedef enum {C_IDLE, C_STRB, C_GAP} fwsr_cst_t;
  fwsr_cst_t   st, next_st;
  logic [4:0]  cnt, next_cnt;       // strobe/gap timer
  logic        ce_n, next_ce_n;
  logic        oe_n, next_oe_n;
  logic        we_n, next_we_n;
  logic        oe, next_oe;
  logic [7:0]  dq, next_dq;
  logic [17:0] ad, next_ad;
  logic [7:0]  rd, next_rd;
  logic        dn, next_dn;

  ////////////////////////////////////////////////////////////////////////
  // next state: a read drops both strobes; only the chosen one rises, the other stays low so the
  // chosen strobe alone marks the cycle edge the device counts
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_oe = oe;
    next_dq = dq;
    next_ad = ad;
    next_rd = rd;
    next_dn = 1'b0;
    unique case (st)
      C_IDLE: begin
        if (cyc.req) begin
          next_ad = cyc.addr;
          next_cnt = fwsr_pkg::TRC_CNT;
          next_st = C_STRB;
          if (cyc.wr) begin
            next_ce_n = 1'b0;
            next_we_n = 1'b0;
            next_oe = 1'b1;
            next_dq = cyc.wdata;
          end else if (cyc.use_ce) begin
            next_oe_n = 1'b0; // cycle framed by chip select
            next_ce_n = 1'b0;
          end else begin
            next_ce_n = 1'b0; // cycle framed by output enable
            next_oe_n = 1'b0;
          end
        end
      end
      C_STRB: begin
        next_cnt = cnt - 5'h01;
        if (cnt == 5'h01) begin
          next_rd = dq_i;          // sample before strobe rises
          next_we_n = 1'b1;        // write: data and select held over rise
          if (!oe && cyc.use_ce) begin
            next_ce_n = 1'b1;      // chip select ends the read
          end else if (!oe) begin
            next_oe_n = 1'b1;      // output enable ends the read
          end
          next_cnt = fwsr_pkg::TGAP_CNT;
          next_st = C_GAP;
        end
      end
      C_GAP: begin
        next_cnt = cnt - 5'h01;
        if (cnt == 5'h01) begin
          next_ce_n = 1'b1;        // release both strobes and the bus
          next_oe_n = 1'b1;
          next_oe = 1'b0;
          next_dn = 1'b1;
          next_st = C_IDLE;
        end
      end
      default: next_st = C_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= C_IDLE;
      cnt <= 5'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      oe <= 1'b0;
      dq <= 8'h00;
      ad <= 18'h0_0000;
      rd <= 8'h00;
      dn <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      oe <= next_oe;
      dq <= next_dq;
      ad <= next_ad;
      rd <= next_rd;
      dn <= next_dn;
    end
  end

  assign ce_n_o = ce_n;
  assign oe_n_o = oe_n;
  assign we_n_o = we_n;
  assign dq_o = dq;
  assign dq_oe_o = oe;
  assign addr_o = ad;
  assign cyc.rdata = rd;
  assign cyc.done = dn;

  // in the strobe phase of a read both strobes are low and write enable is high
  read_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == C_STRB && !oe) |-> (!ce_n && !oe_n && we_n))
    else $error("read cycle strobe pair wrong");
  // in the gap after a read only the chosen framing strobe has risen
  read_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == C_GAP && !oe) |-> (ce_n == cyc.use_ce && oe_n == !cyc.use_ce))
    else $error("read cycle framing strobe wrong");
endmodule

// ==== fwsr_top.sv ====
// toggle-bit status polling controller for a parallel flash, wishbone slave
`timescale 1ns/1ns
// Functional notes
// - read cycles framed by output or chip strobe
// - host reads twice, equal means finished
// - toggling with bit 5 high: recheck, then reset
// - resumed polling restarts from first double read
// - after failure host issues reset command
// - fast added sector commands may skip bit 3
// - sample bit 3 before and after commands (bit 3 is only taken from the S_RD1 and S_RD2 status reads)
// - status reads use a valid address
module fwsr_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  output logic      [17:0] addr_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  input  wire logic        ready_busy_out_i
);
  fwsr_cyc_if cyc ();

  typedef enum {S_IDLE, S_RD1, S_RD2, S_RD3, S_RD4, S_RST}
    fwsr_st_t;
  fwsr_st_t    st, next_st;       // poll sequencer state
  logic        use_ce, next_use_ce;   // read framing choice
  logic        togb, next_togb;       // watch bit 2 instead of bit 6
  logic [17:0] vaddr, next_vaddr;     // valid status address
  logic        busy, next_busy;
  logic        done, next_done;       // sticky: finished
  logic        fail, next_fail;       // sticky: failed, reset sent
  logic        rstreq, next_rstreq;   // sticky: reset command issued
  logic        timer, next_timer;     // last bit 3 sample
  logic [7:0]  first, next_first;     // first sample of a pair
  logic [7:0]  last, next_last;       // last byte read
  logic        req, next_req;
  logic        wr, next_wr;
  logic        rdy_q, next_rdy_q;     // registered ready/busy pin
  logic [31:0] rdat, next_rdat;
  logic        ack, next_ack;
  logic        abort_pend, next_abort_pend; // abort waits for cycle end
  logic        tbit_first, tbit_now;  // watched toggle bit
  logic        wb_hit;                // new access this cycle
  logic        start_wr, abort_wr;

  ////////////////////////////////////////////////////////////////////////
  // wishbone write decode; a start or abort is taken only on the ack edge
  always_comb begin
    wb_hit = wb_cyc_i && wb_stb_i && !ack;
    start_wr = wb_hit && wb_we_i && wb_sel_i[0] &&
               (wb_adr_i == fwsr_pkg::OFF_CTRL) &&
               wb_dat_i[fwsr_pkg::CTRL_START];
    abort_wr = wb_hit && wb_we_i && wb_sel_i[0] &&
               (wb_adr_i == fwsr_pkg::OFF_CTRL) &&
               wb_dat_i[fwsr_pkg::CTRL_ABORT];
    tbit_first = togb ? first[fwsr_pkg::BIT_TOG2] :
                        first[fwsr_pkg::BIT_TOG1];
    tbit_now = togb ? cyc.rdata[fwsr_pkg::BIT_TOG2] :
                      cyc.rdata[fwsr_pkg::BIT_TOG1];
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and poll sequencer next values
  always_comb begin
    next_st = st;
    next_use_ce = use_ce;
    next_togb = togb;
    next_vaddr = vaddr;
    next_busy = busy;
    next_done = done;
    next_fail = fail;
    next_rstreq = rstreq;
    next_timer = timer;
    next_first = first;
    next_last = last;
    next_req = 1'b0;
    next_wr = wr;
    next_rdy_q = ready_busy_out_i; // pin taken as synchronous
    next_ack = wb_hit;
    next_rdat = rdat;
    next_abort_pend = abort_pend;
    // register reads
    if (wb_hit) begin
      unique case (wb_adr_i)
        fwsr_pkg::OFF_CTRL: next_rdat = {29'h0000_0000, togb, use_ce,
                                         busy};
        fwsr_pkg::OFF_ADDR: next_rdat = {14'h0000, vaddr};
        fwsr_pkg::OFF_STAT: next_rdat = {26'h000_0000, rstreq, timer,
                                         rdy_q, fail, done, busy};
        fwsr_pkg::OFF_DATA: next_rdat = {24'h00_0000, last};
        default:            next_rdat = 32'h0000_0000;
      endcase
    end
    // register writes, ignored while a poll runs except abort
    if (wb_hit && wb_we_i && !busy) begin
      if (wb_adr_i == fwsr_pkg::OFF_CTRL && wb_sel_i[0]) begin
        next_use_ce = wb_dat_i[fwsr_pkg::CTRL_USECE];
        next_togb = wb_dat_i[fwsr_pkg::CTRL_TOGB];
      end
      if (wb_adr_i == fwsr_pkg::OFF_ADDR) begin
        if (wb_sel_i[0]) next_vaddr[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_vaddr[15:8] = wb_dat_i[15:8];
        if (wb_sel_i[2]) next_vaddr[17:16] = wb_dat_i[17:16];
      end
    end
    unique case (st)
      S_IDLE: begin
        if (start_wr && !busy) begin
          // a start always begins at the first double read
          next_busy = 1'b1;
          next_done = 1'b0;
          next_fail = 1'b0;
          next_rstreq = 1'b0;
          next_wr = 1'b0;
          next_req = 1'b1;
          next_st = S_RD1;
        end
      end
      S_RD1: begin
        if (cyc.done) begin
          next_first = cyc.rdata; // first of the pair
          next_last = cyc.rdata;
          next_timer = cyc.rdata[fwsr_pkg::BIT_TIMER];
          next_req = 1'b1;
          next_st = S_RD2;
        end
      end
      S_RD2: begin
        if (cyc.done) begin
          next_last = cyc.rdata;
          next_timer = cyc.rdata[fwsr_pkg::BIT_TIMER];
          if (tbit_now == tbit_first) begin
            next_done = 1'b1; // not toggling: finished
            next_busy = 1'b0;
            next_st = S_IDLE;
          end else if (cyc.rdata[fwsr_pkg::BIT_FAIL]) begin
            next_first = cyc.rdata; // bit 5 high: recheck
            next_req = 1'b1;
            next_st = S_RD3;
          end else begin
            next_first = cyc.rdata; // still busy: keep polling
            next_req = 1'b1;
            next_st = S_RD2;
          end
        end
      end
      S_RD3: begin
        if (cyc.done) begin
          next_first = cyc.rdata;
          next_last = cyc.rdata;
          next_req = 1'b1;
          next_st = S_RD4;
        end
      end
      S_RD4: begin
        if (cyc.done) begin
          next_last = cyc.rdata;
          if (tbit_now == tbit_first) begin
            next_done = 1'b1; // stopped as bit 5 rose
            next_busy = 1'b0;
            next_st = S_IDLE;
          end else begin
            next_fail = 1'b1; // failed: send reset command
            next_wr = 1'b1;
            next_req = 1'b1;
            next_st = S_RST;
          end
        end
      end
      S_RST: begin
        if (cyc.done) begin
          next_rstreq = 1'b1;
          next_busy = 1'b0;
          next_wr = 1'b0;
          next_st = S_IDLE;
        end
      end
      default: next_st = S_IDLE;
    endcase
    // abort is remembered until the bus cycle in flight ends, so the
    // host need not time its write; a late one is dropped once idle
    if (!busy) begin
      next_abort_pend = 1'b0;
    end
    if (abort_wr && busy) begin
      next_abort_pend = 1'b1;
    end
    if ((abort_wr || abort_pend) && busy && st != S_RST && cyc.done) begin
      next_busy = 1'b0;
      next_req = 1'b0;
      next_abort_pend = 1'b0;
      next_st = S_IDLE;
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= S_IDLE;
      use_ce <= 1'b0;
      togb <= 1'b0;
      vaddr <= fwsr_pkg::RST_ADDR;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      rstreq <= 1'b0;
      timer <= 1'b0;
      first <= 8'h00;
      last <= 8'h00;
      req <= 1'b0;
      wr <= 1'b0;
      rdy_q <= 1'b1;
      rdat <= fwsr_pkg::RST_CTRL;
      ack <= 1'b0;
      abort_pend <= 1'b0;
    end else begin
      st <= next_st;
      use_ce <= next_use_ce;
      togb <= next_togb;
      vaddr <= next_vaddr;
      busy <= next_busy;
      done <= next_done;
      fail <= next_fail;
      rstreq <= next_rstreq;
      timer <= next_timer;
      first <= next_first;
      last <= next_last;
      req <= next_req;
      wr <= next_wr;
      rdy_q <= next_rdy_q;
      rdat <= next_rdat;
      ack <= next_ack;
      abort_pend <= next_abort_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle engine; status reads go to the programmed valid address
  assign cyc.req = req;
  assign cyc.wr = wr;
  assign cyc.use_ce = use_ce;
  assign cyc.addr = wr ? 18'h0_0000 : vaddr;
  assign cyc.wdata = fwsr_pkg::CMD_RESET;

  fwsr_cycle u_cycle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc     (cyc),
    .dq_i    (dq_i),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o),
    .addr_o  (addr_o),
    .ce_n_o  (ce_n_o),
    .oe_n_o  (oe_n_o),
    .we_n_o  (we_n_o)
  );

  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;

  // equal pair of toggle bits ends the poll as done next cycle
  done_on_equal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_RD2 && cyc.done && tbit_now == tbit_first) |=>
    (done && !busy && st == S_IDLE))
    else $error("equal toggle pair did not finish");
  // toggling with bit 5 high leads to a recheck read
  recheck_fail_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_RD2 && cyc.done && tbit_now != tbit_first &&
     cyc.rdata[fwsr_pkg::BIT_FAIL]) |=> (st == S_RD3 && req))
    else $error("bit 5 high without recheck");
  // failed recheck issues the reset write
  reset_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_RD4 && cyc.done && tbit_now != tbit_first) |=>
    (fail && wr && st == S_RST))
    else $error("failure without reset command");
  // a start always enters the first read
  restart_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == S_IDLE && start_wr && !busy) |=> (st == S_RD1 && req && busy))
    else $error("poll did not restart at first read");
  // status reads drive the programmed valid address on the pins
  valid_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && !oe_n_o && we_n_o) |-> (addr_o == vaddr))
    else $error("status read at wrong address");
endmodule

// ==== fwsr_flash_model.sv ====
// behavioural flash device answering toggle-bit status reads
`timescale 1ns/1ns
module fwsr_flash_model (
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic      [7:0]  dq_o,
  output logic             ready_busy_o
);
  int          left;      // toggling reads still to go
  int          reads;     // completed read cycles
  int          resets;    // reset commands seen
  logic        fl;        // pulse limit exceeded
  logic        sp;        // erase suspended
  logic        tm;        // sector erase timer bit
  logic        t6;        // toggle bit one
  logic        t2;        // toggle bit two
  logic [5:0]  sec;       // sector selected for erase
  logic [17:0] last_addr; // address of the last read
  logic [7:0]  held;      // last value put on the bus
  wire  logic  rd_n = ce_n_i | oe_n_i | ~we_n_i;
  wire  logic  busy = (left > 0) | fl;
  // status byte while busy, array byte once finished
  wire  logic [7:0] cur = busy ? {1'b0, t6, fl, 1'b0, tm, t2, 2'b00}
                               : 8'h5A;
  initial begin
    left = 0; reads = 0; resets = 0; fl = 0; sp = 0; tm = 0;
    t6 = 0; t2 = 0; sec = 6'h00; last_addr = 18'h0_0000; held = 8'h00;
  end
  // bench arms one embedded operation; toggles count from here
  task automatic start_op(input int n, input logic f, input logic s,
                          input logic t, input logic [5:0] k);
    left = n;
    fl = f;
    sp = s; tm = t; sec = k;
  endtask
  // end of a read cycle, framed by either strobe
  always @(posedge rd_n) begin
    held = cur;
    reads++;
    last_addr = addr_i;
    if (busy) begin
      if (!sp) t6 = ~t6;
      if (addr_i[17:12] == sec) t2 = ~t2;
      if (left > 0) left--;
    end
  end
  // reset command ends a failed operation
  always @(posedge we_n_i) begin
    if (!ce_n_i && dq_i == fwsr_pkg::CMD_RESET) begin
      fl = 0; left = 0; resets++;
    end
  end
  // released bus shows the inverse of the last value, never a hold
  always @* dq_o = rd_n ? ~held : cur;
  // open drain pin low while an algorithm runs, high in suspend
  always @* ready_busy_o = !(busy && !sp);
endmodule

// ==== fwsr_top_bench.sv ====
// self-checking bench for the flash status polling controller
`timescale 1ns/1ns
module fwsr_top_bench;
  logic        clk_i = 0, rst_i = 1;   // clock and reset
  logic [3:0]  adr = 4'h0, sel = 4'h0; // wishbone request
  logic [31:0] wdat = 32'h0;           // write data
  logic        we = 0, cyc = 0, stb = 0;
  logic [31:0] wb_dat_o, q;            // read data, last read
  logic        wb_ack_o, dq_oe_o, ce_n_o, oe_n_o, we_n_o, rb;
  logic [7:0]  dq_o, fq;               // controller and flash drive
  logic [17:0] addr_o;
  wire  logic [7:0] dq = dq_oe_o ? dq_o : fq; // resolved data bus
  int          errors = 0, num_checks = 0, r0;
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk_i = ~clk_i;
  fwsr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .addr_o(addr_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .ready_busy_out_i(rb));
  fwsr_flash_model u_flash (.addr_i(addr_o), .dq_i(dq), .ce_n_i(ce_n_o),
    .oe_n_i(oe_n_o), .we_n_i(we_n_o), .dq_o(fq), .ready_busy_o(rb));
  ////////////////////////////////////////////////////////////////////////////
  // compare one value, report at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a; we <= w; wdat <= d; sel <= 4'hF; cyc <= 1; stb <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) errors++;
    q = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  // poll status until the controller leaves busy, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(fwsr_pkg::OFF_STAT, 0, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) errors++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // register reset values and an unmapped offset
  task automatic s_reset();
    wb(fwsr_pkg::OFF_CTRL, 0, 0); chk(q, fwsr_pkg::RST_CTRL);
    wb(fwsr_pkg::OFF_ADDR, 0, 0); chk(q, 32'(fwsr_pkg::RST_ADDR));
    wb(fwsr_pkg::OFF_STAT, 0, 0); chk(q & 32'h3F, 32'h0000_0008);
    wb(4'h2, 0, 0); chk(q, 32'h0000_0000);
  endtask
  // long program: pin low, refusal while busy, done after toggling ends
  task automatic s_done();
    wb(fwsr_pkg::OFF_ADDR, 1, 32'h0000_0100);
    r0 = u_flash.reads;
    u_flash.start_op(20, 0, 0, 0, 6'h3F);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0001);
    wb(fwsr_pkg::OFF_STAT, 0, 0); chk(q & 32'h0F, 32'h0000_0001);
    wb(fwsr_pkg::OFF_ADDR, 1, 32'h0003_FFFF);
    wb(fwsr_pkg::OFF_ADDR, 0, 0); chk(q, 32'h0000_0100);
    wait_idle();
    chk(q & 32'h27, 32'h0000_0002);
    wb(fwsr_pkg::OFF_DATA, 0, 0); chk(q & 32'hFF, 32'h0000_005A);
    chk(32'(u_flash.reads - r0), 32'h15);
    chk(32'(u_flash.last_addr), 32'h0000_0100);
  endtask
  // pulse limit exceeded: recheck, fail, reset command
  task automatic s_fail();
    r0 = u_flash.resets;
    u_flash.start_op(1, 1, 0, 0, 6'h3F);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0001);
    wait_idle();
    chk(q & 32'h27, 32'h0000_0024);
    chk(32'(u_flash.resets - r0), 32'h1);
    chk(32'(u_flash.fl), 32'h0);
  endtask
  // abort mid-poll: stops after the read in flight, no flags set
  task automatic s_abort();
    r0 = u_flash.reads;
    u_flash.start_op(20, 0, 0, 0, 6'h3F);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0001);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0008);
    wait_idle();
    chk(q & 32'h27, 32'h0000_0000);
    chk(32'(u_flash.reads - r0), 32'h1);
  endtask
  // erase suspend: bit 6 still, pin high, timer bit taken
  task automatic s_suspend();
    u_flash.start_op(10, 0, 1, 1, 6'h3F);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0001);
    wait_idle();
    chk(q & 32'h3F, 32'h0000_001A);
  endtask
  // chip select framing watching bit 2 in a selected sector
  task automatic s_bit2();
    wb(fwsr_pkg::OFF_ADDR, 1, 32'h0002_3000);
    r0 = u_flash.reads;
    u_flash.start_op(6, 0, 1, 0, 6'h23);
    wb(fwsr_pkg::OFF_CTRL, 1, 32'h0000_0007);
    wait_idle();
    chk(q & 32'h07, 32'h0000_0002);
    chk(32'(u_flash.reads - r0), 32'h8);
    chk(32'(u_flash.last_addr), 32'h0002_3000);
    wb(fwsr_pkg::OFF_CTRL, 0, 0); chk(q & 32'h07, 32'h0000_0006);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    s_reset();
    s_done();
    s_fail();
    s_abort();
    s_suspend();
    s_bit2();
    end_sim();
  end
  // watchdog against a hung handshake or poll
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule
